// >>> hdl/rwd_defs.vh
`ifndef RWD_DEFS_VH
`define RWD_DEFS_VH

// Register indices on the plain register port
`define RWD_ADDR_OPTION      4'h0
`define RWD_ADDR_STATUS      4'h1
`define RWD_ADDR_COUNT_LO    4'h2
`define RWD_ADDR_COUNT_MID   4'h3
`define RWD_ADDR_COUNT_HI    4'h4

// Option register fields
`define RWD_OPT_RATIO_LSB    0
`define RWD_OPT_RATIO_MSB    2
`define RWD_OPT_ASSIGN_BIT   3
`define RWD_OPT_RESET        8'h00

// Status register fields
`define RWD_ST_TIMEOUT_BIT   0
`define RWD_ST_POWERDOWN_BIT 1
`define RWD_ST_ASLEEP_BIT    2
`define RWD_ST_ENABLED_BIT   3
`define RWD_ST_CAPTURED_BIT  4

// Timing: nominal period and core clock period, both in ns
`define RWD_PERIOD_NS        18000000
`define RWD_CLK_NS           10
`define RWD_RC_DIV           1

`endif

// >>> hdl/rwd_watchdog.v
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`include "rwd_defs.vh"

module rwd_watchdog #(
    parameter CNT_W         = 24,
    parameter TIMEOUT_TICKS = `RWD_PERIOD_NS / `RWD_CLK_NS,
    parameter RC_DIV        = `RWD_RC_DIV
) (
    input  wire       core_clk_in,
    input  wire       reset_in,
    input  wire       watchdog_enable_fuse_in,
    input  wire       clear_watchdog_instr_in,
    input  wire       sleep_instr_in,
    input  wire [3:0] reg_addr_in,
    input  wire [7:0] reg_wdata_in,
    input  wire       reg_write_in,
    input  wire       reg_read_in,
    output reg  [7:0] reg_rdata_out,
    output reg        device_reset_out,
    output reg        wake_out,
    output wire       core_asleep_out,
    output wire       timeout_flag_out,
    output wire       powerdown_flag_out
);

    // Integer forms first, then cut to the register widths on purpose
    localparam integer     LAST_INT  = TIMEOUT_TICKS - 1;
    localparam integer     RC_INT    = RC_DIV - 1;
    localparam [CNT_W-1:0] LAST_TICK = LAST_INT[CNT_W-1:0];
    localparam [15:0]      RC_LAST   = RC_INT[15:0];

    // Fuse pin: three-stage synchroniser, caught once after reset release
    reg        fuse_s1_q;
    reg        fuse_s2_q;
    reg        fuse_s3_q;
    reg        fuse_done_q;
    reg [1:0]  fuse_fill_q;
    reg        enabled_q;

    reg [15:0]      rc_div_q;
    reg             rc_tick_q;
    reg [6:0]       pre_q;
    reg [CNT_W-1:0] watchdog_counter_q;
    reg [7:0]       option_q;
    reg             timeout_flag_q;
    reg             powerdown_flag_q;
    reg             asleep_q;

    wire       restart;
    wire [2:0] ratio;
    wire       pre_assigned;
    wire [6:0] pre_mask;
    wire       pre_tick;
    wire       expire;

    assign restart      = clear_watchdog_instr_in | sleep_instr_in;
    assign ratio        = option_q[`RWD_OPT_RATIO_MSB:`RWD_OPT_RATIO_LSB];
    assign pre_assigned = option_q[`RWD_OPT_ASSIGN_BIT];
    // Mask of low prescaler bits that must all be one; empty mask is 1:1
    assign pre_mask     = pre_assigned ? ~(7'h7f << ratio) : 7'h00;
    assign pre_tick     = rc_tick_q && ((pre_q & pre_mask) == pre_mask);
    // A restart in the expiry cycle wins, so clear and sleep never race a pulse
    assign expire       = enabled_q && pre_tick && !restart
                          && (watchdog_counter_q == LAST_TICK);

    assign core_asleep_out    = asleep_q;
    assign timeout_flag_out   = timeout_flag_q;
    assign powerdown_flag_out = powerdown_flag_q;

    always @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            fuse_s1_q   <= 1'b0;
            fuse_s2_q   <= 1'b0;
            fuse_s3_q   <= 1'b0;
            fuse_done_q <= 1'b0;
            fuse_fill_q <= 2'h0;
            enabled_q   <= 1'b0;
        end
        else
        begin
            fuse_s1_q <= watchdog_enable_fuse_in;
            fuse_s2_q <= fuse_s1_q;
            fuse_s3_q <= fuse_s2_q;
            // Stages two and three hold pin samples only from the third edge on
            if (fuse_fill_q != 2'h3)
                fuse_fill_q <= fuse_fill_q + 2'h1;
            // Waiting for a full pipe keeps the reset zeros from passing as an agreed off
            // A programmed-off fuse keeps the watchdog dead until the next reset
            if (!fuse_done_q && (fuse_fill_q == 2'h3) && (fuse_s2_q == fuse_s3_q))
            begin
                fuse_done_q <= 1'b1;
                enabled_q   <= fuse_s3_q;
            end
        end
    end

    // Free-running oscillator tick; it never looks at sleep or the core clock gate
    // RC_DIV above one models an oscillator slower than the core clock
    always @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rc_div_q  <= 16'h0000;
            rc_tick_q <= 1'b0;
        end
        else if (rc_div_q == RC_LAST)
        begin
            rc_div_q  <= 16'h0000;
            rc_tick_q <= 1'b1;
        end
        else
        begin
            rc_div_q  <= rc_div_q + 16'h0001;
            rc_tick_q <= 1'b0;
        end
    end

    always @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            pre_q              <= 7'h00;
            watchdog_counter_q <= {CNT_W{1'b0}};
        end
        // A restart or a dead watchdog holds prescaler and counter at zero
        else if (restart || !enabled_q)
        begin
            pre_q              <= 7'h00;
            watchdog_counter_q <= {CNT_W{1'b0}};
        end
        else if (rc_tick_q)
        begin
            // Prescaler runs only when assigned; unassigned it stays at zero
            pre_q <= pre_assigned ? (pre_tick ? 7'h00 : pre_q + 7'h01) : 7'h00;
            if (pre_tick)
            begin
                if (expire)
                    watchdog_counter_q <= {CNT_W{1'b0}};
                else
                    watchdog_counter_q <= watchdog_counter_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            timeout_flag_q   <= 1'b1;
            powerdown_flag_q <= 1'b1;
            asleep_q         <= 1'b0;
            device_reset_out <= 1'b0;
            wake_out         <= 1'b0;
        end
        else
        begin
            // The sleep state picks which of the two pulses an expiry gives
            device_reset_out <= expire && !asleep_q;
            wake_out         <= expire && asleep_q;
            if (expire)
                asleep_q <= 1'b0;
            else if (sleep_instr_in)
                asleep_q <= 1'b1;
            // A clear blocks expiry in its own cycle, so a clear always sets the flag
            if (expire)
                timeout_flag_q <= 1'b0;
            else if (clear_watchdog_instr_in)
                timeout_flag_q <= 1'b1;
            if (clear_watchdog_instr_in)
                powerdown_flag_q <= 1'b1;
            else if (sleep_instr_in)
                powerdown_flag_q <= 1'b0;
        end
    end

    // Option register write
    // Upper option bits are not stored and read back as zero
    always @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
            option_q <= `RWD_OPT_RESET;
        else if (reg_write_in && (reg_addr_in == `RWD_ADDR_OPTION))
            option_q <= {4'h0, reg_wdata_in[3:0]};
    end

    // Read data stand in the cycle after the strobe only
    always @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
            reg_rdata_out <= 8'h00;
        else if (!reg_read_in)
            reg_rdata_out <= 8'h00;
        else
        begin
            case (reg_addr_in)
                `RWD_ADDR_OPTION:    reg_rdata_out <= option_q;
                `RWD_ADDR_STATUS:    reg_rdata_out <= {3'h0, fuse_done_q, enabled_q,
                                                       asleep_q, powerdown_flag_q,
                                                       timeout_flag_q};
                // Counter bytes are live, so they may move between byte reads
                `RWD_ADDR_COUNT_LO:  reg_rdata_out <= watchdog_counter_q[7:0];
                `RWD_ADDR_COUNT_MID: reg_rdata_out <= watchdog_counter_q[15:8];
                `RWD_ADDR_COUNT_HI:  reg_rdata_out <= watchdog_counter_q[23:16];
                default:             reg_rdata_out <= 8'h00;
            endcase
        end
    end

endmodule

// >>> testbench/rwd_watchdog_props.sv
`timescale 1ns/1ns
module rwd_watchdog_props #(
    parameter TIMEOUT_TICKS = 8
) (
    input wire core_clk_in,
    input wire reset_in,
    input wire watchdog_enable_fuse_in,
    input wire clear_watchdog_instr_in,
    input wire sleep_instr_in,
    input wire device_reset_out,
    input wire wake_out,
    input wire core_asleep_out,
    input wire timeout_flag_out,
    input wire powerdown_flag_out
);
    wire        rst_s = clear_watchdog_instr_in | sleep_instr_in;
    wire        exp_s = device_reset_out | wake_out;
    reg  [31:0] gap_q;
    // Cycles since the last restart or expiry, a floor for the period
    always @(posedge core_clk_in or posedge reset_in)
        gap_q <= reset_in ? 32'h0 : rst_s ? 32'h0 : exp_s ? 32'h1 : gap_q + 32'h1;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    property p_period; exp_s |-> gap_q >= TIMEOUT_TICKS; endproperty
    a_period: assert property (p_period) else $error("time-out too early");
    property p_awake; device_reset_out |-> !$past(core_asleep_out); endproperty
    a_awake: assert property (p_awake) else $error("reset while asleep");
    property p_wake; wake_out |-> $past(core_asleep_out) && !core_asleep_out; endproperty
    a_wake: assert property (p_wake) else $error("bad wake");
    property p_toflag; exp_s |-> !timeout_flag_out; endproperty
    a_toflag: assert property (p_toflag) else $error("flag kept");
    property p_fuse; !watchdog_enable_fuse_in [*8] |-> !exp_s; endproperty
    a_fuse: assert property (p_fuse) else $error("expiry while off");
    property p_restart; rst_s |=> !exp_s [*4]; endproperty
    a_restart: assert property (p_restart) else $error("expiry after restart");
    property p_clear;
        clear_watchdog_instr_in |=> timeout_flag_out && powerdown_flag_out;
    endproperty
    a_clear: assert property (p_clear) else $error("clear flags wrong");
    property p_sleep;
        sleep_instr_in && !clear_watchdog_instr_in |=> core_asleep_out && !powerdown_flag_out;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep state wrong");
    c_rst: cover property (device_reset_out);
    c_wake: cover property (wake_out);
    c_clr: cover property (clear_watchdog_instr_in ##1 timeout_flag_out);
endmodule

bind rwd_watchdog rwd_watchdog_props #(.TIMEOUT_TICKS(TIMEOUT_TICKS)) props_u (
    .core_clk_in, .reset_in, .watchdog_enable_fuse_in, .clear_watchdog_instr_in,
    .sleep_instr_in, .device_reset_out, .wake_out, .core_asleep_out,
    .timeout_flag_out, .powerdown_flag_out);

// >>> testbench/rwd_watchdog_tb.sv
`timescale 1ns/1ns
module rwd_watchdog_tb;
    localparam T = 8;
    reg       core_clk_in = 0, reset_in = 1, watchdog_enable_fuse_in = 1;
    reg       clear_watchdog_instr_in = 0, sleep_instr_in = 0, reg_write_in = 0, reg_read_in = 0;
    reg [3:0] reg_addr_in = 4'h0;
    reg [7:0] reg_wdata_in = 8'h00;
    wire [7:0] reg_rdata_out;
    wire      device_reset_out, wake_out, core_asleep_out, timeout_flag_out, powerdown_flag_out;
    integer   error_cnt = 0, n_tests = 0, cyc = 0, r, n;
    rwd_watchdog #(.TIMEOUT_TICKS(T), .RC_DIV(1)) dut_u (.core_clk_in, .reset_in,
        .watchdog_enable_fuse_in, .clear_watchdog_instr_in, .sleep_instr_in, .reg_addr_in,
        .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .device_reset_out,
        .wake_out, .core_asleep_out, .timeout_flag_out, .powerdown_flag_out);
    always #5 core_clk_in = ~core_clk_in;
    task print_verdict;
        begin
            if (error_cnt == 0 && n_tests > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    always @(posedge core_clk_in)
    begin
        cyc = cyc + 1;
        if (cyc == 10000)
        begin
            error_cnt = error_cnt + 1;
            print_verdict;
        end
    end
    task chk(input [63:0] name, input [7:0] exp, input [7:0] got);
        begin
            n_tests = n_tests + 1;
            if (got !== exp)
            begin
                error_cnt = error_cnt + 1;
                $display("BAD %0s exp %h got %h", name, exp, got);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            reg_addr_in <= a;
            reg_wdata_in <= d;
            reg_write_in <= 1'b1;
            @(posedge core_clk_in);
            reg_write_in <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [7:0] exp);
        begin
            reg_addr_in <= a;
            reg_read_in <= 1'b1;
            @(posedge core_clk_in);
            reg_read_in <= 1'b0;
            #1 chk("rdata", exp, reg_rdata_out);
            @(posedge core_clk_in);
        end
    endtask
    // Restart by clear or sleep, then time the pulse that follows
    task go(input slp, input [7:0] opt, input integer lo);
        begin
            wr(4'h0, opt);
            clear_watchdog_instr_in <= !slp;
            sleep_instr_in <= slp;
            @(posedge core_clk_in);
            clear_watchdog_instr_in <= 1'b0;
            sleep_instr_in <= 1'b0;
            n = 0;
            #1;
            while (n < lo + 4 && device_reset_out !== 1'b1 && wake_out !== 1'b1)
            begin
                @(posedge core_clk_in);
                #1 n = n + 1;
            end
            chk("period", 8'h01, {7'h0, n >= lo && n <= lo + 3});
            chk("waken", {7'h0, slp}, {7'h0, wake_out});
            chk("toflag", 8'h00, {7'h0, timeout_flag_out});
            chk("devrst", {7'h0, !slp}, {7'h0, device_reset_out});
            chk("asleep", 8'h00, {7'h0, core_asleep_out});
            @(posedge core_clk_in);
        end
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk_in);
        reset_in <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        rd(4'h1, 8'h1b);
        wr(4'h0, 8'hff);
        rd(4'h0, 8'h0f);
        wr(4'h1, 8'h00);
        rd(4'h1, 8'h1b);
        rd(4'hf, 8'h00);
        for (r = 0; r < 8; r = r + 1)
            go(1'b0, 8'h08 | r[7:0], T << r);
        go(1'b0, 8'h07, T);
        go(1'b1, 8'h03, T);
        wr(4'h0, 8'h00);
        repeat (6)
        begin
            clear_watchdog_instr_in <= 1'b1;
            @(posedge core_clk_in);
            clear_watchdog_instr_in <= 1'b0;
            repeat (5) @(posedge core_clk_in);
        end
        #1 chk("toflag", 8'h01, {7'h0, timeout_flag_out});
        chk("pdflag", 8'h01, {7'h0, powerdown_flag_out});
        @(posedge core_clk_in);
        clear_watchdog_instr_in <= 1'b1;
        @(posedge core_clk_in);
        clear_watchdog_instr_in <= 1'b0;
        rd(4'h2, 8'h00);
        rd(4'h3, 8'h00);
        // A disabled fuse must leave a sleeping core asleep for good
        reset_in <= 1'b1;
        watchdog_enable_fuse_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        reset_in <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        rd(4'h1, 8'h13);
        sleep_instr_in <= 1'b1;
        @(posedge core_clk_in);
        sleep_instr_in <= 1'b0;
        repeat (100) @(posedge core_clk_in);
        #1 chk("asleep", 8'h01, {7'h0, core_asleep_out});
        chk("toflag", 8'h01, {7'h0, timeout_flag_out});
        print_verdict;
    end
endmodule
